//--- verilog/gser_defines.vh
// Constants of the status byte and event reporter
// Contract
// - Status byte bits 0-3 carry status code
// - Status bit 5 flags abnormal condition
// - Status bit 6 shows active service request
// - System events: bytes 65-69, codes 401-405
// - Parse failures: byte 97, codes 101-109
// - Execution failures: byte 98, codes 201-205
// - Internal malfunction: byte 99, codes 303-307
// - Power-on event after every power cycle
// - Completion event on store-mode single acquisition
// - User-request event on front-panel key
// - Plotter-done event when plot finishes
// - Supply-recovered event when fault clears
// - Completion request enable, off after power-up
// - Event query returns last polled event
// - Returned event code is cleared
// - Second poll discards first poll's code
// - Disabled: query only, status byte zero
// - Ten-entry LIFO, oldest dropped on overflow
// - Disabled: poll gives zero, no request
// - Service request enable defaults on
`ifndef GSER_DEFINES_VH
`define GSER_DEFINES_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define GSER_ADDR_CTRL    4'h0
`define GSER_ADDR_POLL    4'h4
`define GSER_ADDR_EVENT   4'h8
`define GSER_ADDR_STATE   4'hc

// ------------------------------------------------------------
// Control fields and reset values
// ------------------------------------------------------------
`define GSER_CTRL_SRE_BIT 0
`define GSER_CTRL_CRE_BIT 1
`define GSER_SRE_RESET    1'b1
`define GSER_CRE_RESET    1'b0

// ------------------------------------------------------------
// Status byte fields and event code bases
// ------------------------------------------------------------
`define GSER_SB_SRQ_BIT   6
`define GSER_SB_ABN_BIT   5
`define GSER_CODE_CMD     9'h064
`define GSER_CODE_EXE     9'h0c8
`define GSER_CODE_INT     9'h12c
`define GSER_CODE_SYS     9'h190
`define GSER_CODE_PWR     9'h191
`define GSER_CODE_OPC     9'h192
`define GSER_CODE_USR     9'h193
`define GSER_CODE_PLT     9'h194
`define GSER_CODE_REC     9'h195
`define GSER_SC_CMD       4'h1
`define GSER_SC_EXE       4'h2
`define GSER_SC_INT       4'h3

// ------------------------------------------------------------
// AXI responses
// ------------------------------------------------------------
`define GSER_RESP_OKAY    2'b00
`define GSER_RESP_SLVERR  2'b10

`endif

//--- verilog/gser_top.v
// Status byte, service request and event LIFO with an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "gser_defines.vh"

module gser_top #(
	parameter DEPTH = 10
) (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address and data
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Instrument events, same clock domain
	input  wire        acq_single_done,
	input  wire        display_store,
	input  wire        plot_done,
	input  wire        pll_fault,
	input  wire        overheat_fault,
	input  wire        err_valid,
	input  wire [8:0]  err_code,
	// Front-panel request key pin
	input  wire        req_key_n,
	// Status outputs
	output reg         srq_reg,
	output reg  [7:0]  status_byte_reg
);

	// ------------------------------------------------------------
	// Status byte of an event code
	// ------------------------------------------------------------
	function [7:0] sb_of;
		input [8:0] c;
		input       rq;
		reg   [7:0] b;
		reg   [8:0] d;
		begin
			b = 8'h00;
			d = c - `GSER_CODE_SYS;
			if (c > `GSER_CODE_SYS)
			begin
				// System codes count up from the base, so the offset is the class code
				b[3:0] = d[3:0];
			end
			else if (c > `GSER_CODE_INT)
			begin
				b[3:0] = `GSER_SC_INT;
				b[`GSER_SB_ABN_BIT] = 1'b1;
			end
			else if (c > `GSER_CODE_EXE)
			begin
				b[3:0] = `GSER_SC_EXE;
				b[`GSER_SB_ABN_BIT] = 1'b1;
			end
			else if (c > `GSER_CODE_CMD)
			begin
				b[3:0] = `GSER_SC_CMD;
				b[`GSER_SB_ABN_BIT] = 1'b1;
			end
			b[`GSER_SB_SRQ_BIT] = rq & (c != 9'h000);
			sb_of = b;
		end
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	reg  [8:0] stk_reg [0:DEPTH-1];
	reg  [3:0] cnt_reg;
	reg  [8:0] ann_reg;
	reg        ann_valid_reg;
	reg        sre_reg;
	reg        cre_reg;
	reg  [4:0] sys_pend_reg;
	reg        pwr_pend_reg;
	reg        key_s1_reg;
	reg        key_s2_reg;
	reg        key_s3_reg;
	reg        fault_d_reg;
	integer    i;

	wire       fault_now  = pll_fault | overheat_fault;
	// Third flip-flop only serves the edge detector; the detector never reads the first
	wire       key_press  = key_s3_reg & ~key_s2_reg;
	wire       top_valid  = (cnt_reg != 4'h0);
	wire [8:0] top_code   = top_valid ? stk_reg[0] : 9'h000;
	// A completion event only calls for service when its own enable is on
	wire       top_req    = top_valid & ((top_code != `GSER_CODE_OPC) | cre_reg);
	wire       srq_next   = sre_reg & top_req;

	// ------------------------------------------------------------
	// Event raising
	// ------------------------------------------------------------
	wire [4:0] sys_set;
	assign sys_set[0] = pwr_pend_reg;
	assign sys_set[1] = acq_single_done & display_store;
	assign sys_set[2] = key_press;
	assign sys_set[3] = plot_done;
	assign sys_set[4] = fault_d_reg & ~fault_now;

	reg  [4:0] sys_clr;
	reg  [8:0] sys_code;
	always @*
	begin
		sys_clr  = 5'h00;
		sys_code = 9'h000;
		if (sys_pend_reg[0])
		begin
			sys_clr[0] = 1'b1;
			sys_code   = `GSER_CODE_PWR;
		end
		else if (sys_pend_reg[1])
		begin
			sys_clr[1] = 1'b1;
			sys_code   = `GSER_CODE_OPC;
		end
		else if (sys_pend_reg[2])
		begin
			sys_clr[2] = 1'b1;
			sys_code   = `GSER_CODE_USR;
		end
		else if (sys_pend_reg[3])
		begin
			sys_clr[3] = 1'b1;
			sys_code   = `GSER_CODE_PLT;
		end
		else if (sys_pend_reg[4])
		begin
			sys_clr[4] = 1'b1;
			sys_code   = `GSER_CODE_REC;
		end
	end

	// Errors go straight in; system events wait until err_valid drops
	wire       push      = err_valid | (sys_pend_reg != 5'h00);
	wire [8:0] push_code = err_valid ? err_code : sys_code;
	wire [4:0] sys_take  = err_valid ? 5'h00 : sys_clr;

	// ------------------------------------------------------------
	// AXI4-Lite read side and its side effects
	// ------------------------------------------------------------
	wire ar_hs   = s_axi_arvalid & s_axi_arready;
	wire poll_rd = ar_hs & (s_axi_araddr == `GSER_ADDR_POLL);
	wire evt_rd  = ar_hs & (s_axi_araddr == `GSER_ADDR_EVENT);

	// A poll with requests on moves the top code to the announced slot
	wire poll_pop = poll_rd & sre_reg & top_valid;
	// A query with nothing announced takes the newest pending code
	wire evt_pop  = evt_rd & ~(sre_reg & ann_valid_reg) & top_valid;
	wire pop      = poll_pop | evt_pop;

	reg  [31:0] rd_data;
	reg  [1:0]  rd_resp;
	always @*
	begin
		rd_data = 32'h0000_0000;
		rd_resp = `GSER_RESP_OKAY;
		case (s_axi_araddr)
		`GSER_ADDR_CTRL:
			rd_data[1:0] = {cre_reg, sre_reg};
		`GSER_ADDR_POLL:
			if (sre_reg)
			begin
				rd_data[7:0] = sb_of(top_code, srq_next);
			end
		`GSER_ADDR_EVENT:
			if (sre_reg & ann_valid_reg)
			begin
				rd_data[8:0] = ann_reg;
			end
			else
			begin
				rd_data[8:0] = top_code;
			end
		`GSER_ADDR_STATE:
			rd_data[13:0] = {ann_reg, ann_valid_reg, cnt_reg};
		default:
			rd_resp = `GSER_RESP_SLVERR;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `GSER_RESP_OKAY;
		end
		else
		begin
			// No new address is taken while an answer is still waiting
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			// Data and side effects are taken at the same handshake edge
			if (ar_hs)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_resp;
			end
			else if (s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write side: address and data are taken together
	// ------------------------------------------------------------
	// Both channels must be valid; taking them together keeps one write at a time
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
	wire wr_hs = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
	wire wr_ok = (s_axi_awaddr == `GSER_ADDR_CTRL) | (s_axi_awaddr == `GSER_ADDR_POLL)
		| (s_axi_awaddr == `GSER_ADDR_EVENT) | (s_axi_awaddr == `GSER_ADDR_STATE);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `GSER_RESP_OKAY;
			sre_reg       <= `GSER_SRE_RESET;
			cre_reg       <= `GSER_CRE_RESET;
		end
		else
		begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (wr_hs)
			begin
				s_axi_bvalid <= 1'b1;
				// Unmapped writes still get an answer so the master never hangs
				s_axi_bresp  <= wr_ok ? `GSER_RESP_OKAY : `GSER_RESP_SLVERR;
				if ((s_axi_awaddr == `GSER_ADDR_CTRL) && s_axi_wstrb[0])
				begin
					sre_reg <= s_axi_wdata[`GSER_CTRL_SRE_BIT];
					cre_reg <= s_axi_wdata[`GSER_CTRL_CRE_BIT];
				end
			end
			else if (s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Event sources
	// ------------------------------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// Idle-high reset values keep a false key press out after reset
			key_s1_reg   <= 1'b1;
			key_s2_reg   <= 1'b1;
			key_s3_reg   <= 1'b1;
			fault_d_reg  <= 1'b0;
			// Every reset release counts as a power cycle and raises power-on
			pwr_pend_reg <= 1'b1;
			sys_pend_reg <= 5'h00;
		end
		else
		begin
			key_s1_reg   <= req_key_n;
			key_s2_reg   <= key_s1_reg;
			key_s3_reg   <= key_s2_reg;
			fault_d_reg  <= fault_now;
			pwr_pend_reg <= 1'b0;
			// A new event in the cycle of its own take is kept
			sys_pend_reg <= (sys_pend_reg & ~sys_take) | sys_set;
		end
	end

	// ------------------------------------------------------------
	// Event LIFO and announced code
	// ------------------------------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_reg <= 4'h0;
			for (i = 0; i < DEPTH; i = i + 1)
			begin
				stk_reg[i] <= 9'h000;
			end
		end
		// A push and a pop together replace the top; the count stays
		else if (push && pop)
		begin
			stk_reg[0] <= push_code;
		end
		else if (push)
		begin
			for (i = DEPTH - 1; i > 0; i = i - 1)
			begin
				stk_reg[i] <= stk_reg[i-1];
			end
			stk_reg[0] <= push_code;
			// Full stack: the shift has already dropped the oldest entry
			if (cnt_reg != DEPTH[3:0])
			begin
				cnt_reg <= cnt_reg + 4'h1;
			end
		end
		else if (pop)
		begin
			for (i = 0; i < DEPTH - 1; i = i + 1)
			begin
				stk_reg[i] <= stk_reg[i+1];
			end
			stk_reg[DEPTH-1] <= 9'h000;
			cnt_reg <= cnt_reg - 4'h1;
		end
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ann_reg       <= 9'h000;
			ann_valid_reg <= 1'b0;
		end
		// A new poll overwrites an unqueried announced code, which is lost
		else if (poll_pop)
		begin
			ann_reg       <= top_code;
			ann_valid_reg <= 1'b1;
		end
		else if (evt_rd && sre_reg && ann_valid_reg)
		begin
			ann_reg       <= 9'h000;
			ann_valid_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Service request line and status byte view
	// ------------------------------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			srq_reg         <= 1'b0;
			status_byte_reg <= 8'h00;
		end
		else
		begin
			// The byte view is what the next poll would return
			srq_reg         <= srq_next;
			status_byte_reg <= sre_reg ? sb_of(top_code, srq_next) : 8'h00;
		end
	end

endmodule
`default_nettype wire

//--- test/gser_top_monitor.sv
// Checker of the status byte, request line and register bus answers
`timescale 1ns/10ps
`default_nettype none
`include "gser_defines.vh"

module gser_top_monitor #(
	parameter DEPTH = 10
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic [3:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [3:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	// Status outputs
	input wire logic        srq_reg,
	input wire logic [7:0]  status_byte_reg
);
	logic sre_q;
	logic cre_q;
	wire  wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Enables as last written over the bus; the port list hides the real ones
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sre_q <= `GSER_SRE_RESET;
			cre_q <= `GSER_CRE_RESET;
		end
		else if (wr_hit && s_axi_awaddr == `GSER_ADDR_CTRL && s_axi_wstrb[0])
		begin
			sre_q <= s_axi_wdata[`GSER_CTRL_SRE_BIT];
			cre_q <= s_axi_wdata[`GSER_CTRL_CRE_BIT];
		end
	end

	sequence s_released;
		$rose(aresetn);
	endsequence
	sequence s_first_report;
		##[1:4] (srq_reg && status_byte_reg == 8'h41);
	endsequence

	a_power_on_report: assert property (s_released |-> s_first_report)
		else $error("power-on report missing");
	a_class_code: assert property (status_byte_reg != 8'h00 |->
		status_byte_reg[3:0] inside {[1:5]} && !status_byte_reg[7] && !status_byte_reg[4])
		else $error("bad status class code");
	a_abnormal_flag: assert property (status_byte_reg[5] |->
		status_byte_reg[3:0] inside {[1:3]}) else $error("abnormal flag on system class");
	a_disabled_quiet: assert property (!sre_q && !$past(sre_q, 3) |->
		status_byte_reg == 8'h00 && !srq_reg) else $error("status shown while disabled");
	a_completion_quiet: assert property (status_byte_reg[3:0] == 4'h2 &&
		!status_byte_reg[5] && !$past(cre_q) |-> !srq_reg)
		else $error("completion request unmasked");
	a_request_bit: assert property (srq_reg == status_byte_reg[`GSER_SB_SRQ_BIT])
		else $error("request bit differs from request line");
	a_srq_has_byte: assert property (srq_reg |->
		status_byte_reg != 8'h00 || $past(status_byte_reg) != 8'h00)
		else $error("request without pending byte");
	a_write_answer: assert property (wr_hit |=> s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'b00
		|=> s_axi_rresp == `GSER_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule

bind gser_top gser_top_monitor #(.DEPTH(DEPTH)) i_mon (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .srq_reg, .status_byte_reg);
`default_nettype wire

//--- test/gser_ctl_model.sv
// Remote controller model: one AXI4-Lite access per request from the bench
`timescale 1ns/10ps
`default_nettype none

module gser_ctl_model (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Request from the bench
	input  wire logic        go,
	input  wire logic        go_wr,
	input  wire logic [3:0]  go_addr,
	input  wire logic [31:0] go_data,
	output var  logic        done,
	output var  logic [31:0] got_data,
	output var  logic [1:0]  got_resp,
	// AXI4-Lite master
	output var  logic [3:0]  s_axi_awaddr,
	output var  logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output var  logic [31:0] s_axi_wdata,
	output wire logic [3:0]  s_axi_wstrb,
	output var  logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output var  logic        s_axi_bready,
	output var  logic [3:0]  s_axi_araddr,
	output var  logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output var  logic        s_axi_rready
);
	logic busy;

	assign s_axi_wstrb = 4'hf;
	initial
		{busy, done, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready,
			s_axi_awaddr, s_axi_araddr, s_axi_wdata, got_data, got_resp} = '0;

	always @(posedge aclk)
	begin
		done <= 1'b0;
		if (!aresetn)
			{busy, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} <= 6'h00;
		else
		begin
			// Payload only moves when idle, so it stays put until each channel is taken
			if (go && !busy)
			begin
				busy <= 1'b1;
				{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{go_wr}};
				{s_axi_arvalid, s_axi_rready} <= {2{!go_wr}};
				s_axi_awaddr <= go_addr;
				s_axi_araddr <= go_addr;
				s_axi_wdata <= go_data;
			end
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
			begin
				{busy, s_axi_bready, done} <= 3'b001;
				got_resp <= s_axi_bresp;
			end
			if (s_axi_rvalid && s_axi_rready)
			begin
				{busy, s_axi_rready, done} <= 3'b001;
				got_resp <= s_axi_rresp;
				got_data <= s_axi_rdata;
			end
		end
	end
endmodule
`default_nettype wire

//--- test/gser_top_tb_top.sv
// Testbench of the status byte and event reporter
`timescale 1ns/10ps
`default_nettype none
`include "gser_defines.vh"

module gser_top_tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic        go, go_wr, done, srq_reg, err_valid, req_key_n;
	logic [3:0]  go_addr, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] go_data, got_data, s_axi_wdata, s_axi_rdata;
	logic [1:0]  got_resp, s_axi_bresp, s_axi_rresp;
	logic [7:0]  status_byte_reg;
	logic [8:0]  err_code;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        acq_single_done, display_store, plot_done, pll_fault, overheat_fault;
	int          bad_count = 0, check_count = 0;
	logic [8:0]  codes [13] = '{9'h065, 9'h067, 9'h06a, 9'h06c, 9'h06d, 9'h0c9, 9'h0cb,
		9'h0cc, 9'h0cd, 9'h12f, 9'h131, 9'h132, 9'h133};

	always #20 aclk = ~aclk;

	gser_top #(.DEPTH(10)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .acq_single_done, .display_store, .plot_done, .pll_fault,
		.overheat_fault, .err_valid, .err_code, .req_key_n, .srq_reg, .status_byte_reg);
	gser_ctl_model i_ctl (.aclk, .aresetn, .go, .go_wr, .go_addr, .go_data, .done, .got_data,
		.got_resp, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [33:0] seen, input logic [33:0] want);
		check_count++;
		if (seen !== want)
		begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	// Waits on the model's done pulse; a lost answer counts as a mismatch
	task automatic xfer(input logic wr, input logic [3:0] addr, input logic [31:0] data);
		int n;
		n = 0;
		@(posedge aclk);
		{go, go_wr, go_addr, go_data} <= {1'b1, wr, addr, data};
		@(posedge aclk);
		go <= 1'b0;
		while (done !== 1'b1 && n < 40)
		begin
			@(posedge aclk);
			n++;
		end
		if (n == 40)
			chk(32'h0, 32'h1);
	endtask
	task automatic rd(input logic [3:0] addr, input logic [31:0] want);
		xfer(1'b0, addr, 32'h0);
		chk({got_resp, got_data}, {`GSER_RESP_OKAY, want});
	endtask
	task automatic wt;
		repeat (6) @(posedge aclk);
	endtask
	task automatic err(input logic [8:0] c);
		@(posedge aclk);
		{err_valid, err_code} <= {1'b1, c};
		@(posedge aclk);
		err_valid <= 1'b0;
	endtask
	task automatic acq;
		@(posedge aclk);
		acq_single_done <= 1'b1;
		@(posedge aclk);
		acq_single_done <= 1'b0;
		wt;
	endtask
	task automatic power_up;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
		chk({srq_reg, status_byte_reg}, 32'h141);
		rd(`GSER_ADDR_CTRL, 32'h1);
		rd(`GSER_ADDR_POLL, 32'h41);
		chk({srq_reg, status_byte_reg}, 32'h0);
		rd(`GSER_ADDR_EVENT, `GSER_CODE_PWR);
		rd(`GSER_ADDR_EVENT, 32'h0);
		rd(`GSER_ADDR_POLL, 32'h0);
	endtask

	initial
	begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		tally_and_finish;
	end

	initial
	begin
		{go, go_wr, go_addr, go_data, err_valid, err_code} = '0;
		{acq_single_done, display_store, plot_done, pll_fault, overheat_fault} = 5'h00;
		req_key_n = 1'b1;
		power_up;
		err(codes[0]);
		err(codes[5]);
		err(codes[9]);
		wt;
		rd(`GSER_ADDR_STATE, 32'h3);
		rd(`GSER_ADDR_POLL, 32'h63);
		rd(`GSER_ADDR_STATE, {codes[9], 1'b1, 4'h2});
		rd(`GSER_ADDR_EVENT, codes[9]);
		rd(`GSER_ADDR_POLL, 32'h62);
		rd(`GSER_ADDR_POLL, 32'h61);
		rd(`GSER_ADDR_EVENT, codes[0]);
		rd(`GSER_ADDR_EVENT, 32'h0);
		plot_done <= 1'b1;
		@(posedge aclk);
		plot_done <= 1'b0;
		wt;
		rd(`GSER_ADDR_POLL, 32'h44);
		rd(`GSER_ADDR_EVENT, `GSER_CODE_PLT);
		pll_fault <= 1'b1;
		wt;
		{pll_fault, overheat_fault} <= 2'b01;
		wt;
		overheat_fault <= 1'b0;
		wt;
		rd(`GSER_ADDR_POLL, 32'h45);
		rd(`GSER_ADDR_EVENT, `GSER_CODE_REC);
		rd(`GSER_ADDR_EVENT, 32'h0);
		req_key_n <= 1'b0;
		wt;
		req_key_n <= 1'b1;
		wt;
		rd(`GSER_ADDR_POLL, 32'h43);
		rd(`GSER_ADDR_EVENT, `GSER_CODE_USR);
		display_store <= 1'b1;
		acq;
		chk({srq_reg, status_byte_reg}, 32'h002);
		rd(`GSER_ADDR_EVENT, `GSER_CODE_OPC);
		xfer(1'b1, `GSER_ADDR_CTRL, 32'h3);
		chk(got_resp, `GSER_RESP_OKAY);
		acq;
		chk({srq_reg, status_byte_reg}, 32'h142);
		rd(`GSER_ADDR_EVENT, `GSER_CODE_OPC);
		xfer(1'b1, `GSER_ADDR_CTRL, 32'h0);
		err(codes[2]);
		wt;
		chk({srq_reg, status_byte_reg}, 32'h0);
		rd(`GSER_ADDR_POLL, 32'h0);
		rd(`GSER_ADDR_EVENT, codes[2]);
		foreach (codes[i])
			err(codes[i]);
		wt;
		rd(`GSER_ADDR_STATE, 32'ha);
		for (int i = 12; i >= 3; i--)
			rd(`GSER_ADDR_EVENT, codes[i]);
		rd(`GSER_ADDR_EVENT, 32'h0);
		xfer(1'b0, 4'h1, 32'h0);
		chk({got_resp, got_data}, {`GSER_RESP_SLVERR, 32'h0});
		xfer(1'b1, 4'h2, 32'h3);
		chk(got_resp, `GSER_RESP_SLVERR);
		power_up;
		tally_and_finish;
	end
endmodule
`default_nettype wire
